// ### hdl/low_power_frame_sequencer.sv
// low power frame sequencer: registers, trigger detect and burst timing
`include "lp_seq_params.svh"
`default_nettype none

// What the document asks of this block, its host and software
// [R01] 0x63 selects low power, 0xAB normal
// [R02] phase field 11 low power, 01 normal
// [R03] mode field picks streaming or snapshot kind
// [R04] bit7 rising write starts internal snapshot burst
// [R05] stream active count, sleep idle count, repeat
// [R06] low frame rate integration capped at frame-40 rows
// [R07] internal snapshot: burst per request, then idle
// [R08] pin rising edge wakes, bursts, sleeps again
// [R09] host holds trigger pulse five clocks minimum
// [R10] wake 16384 clocks, pixel reset, then integrate
// [R11] trigger to integration 16388 clocks plus 11 rows
// [R12] frame start packet 8 rows after integration
// [R13] host discards first frame after long sleep
// [R14] host may retrigger after frame; keep 10fps
// [R15] row period register counts input clocks
// [R16] software sets rows per base frame
// [R17] software leaves debug register at 0x89
// [R18] output power down in sleep when enabled
// [R19] pin synchronised, rising edges, ignored while busy
module low_power_frame_sequencer #(
   parameter int WAKE_CYC = `WAKE_CYC,
   parameter int EXP_DLY_CYC = `EXP_DLY_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register access from the serial control bus
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // trigger pin
   input wire logic frame_sync_trigger_in_i,
   // sequencing outputs
   output logic low_power_o,
   output logic asleep_o,
   output logic streaming_o,
   output logic integrating_o,
   output logic integ_start_o,
   output logic frame_start_o,
   output logic output_pd_o,
   output logic [15:0] max_integ_rows_o
);

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // clock part of pixel reset: what is left after trigger latency and wake
   localparam int PIXRST_CYC = EXP_DLY_CYC - WAKE_CYC - `TRIG_LAT_CYC;

   logic [7:0] out_pwr_ff, debug_ff, power_opt_ff, phase_ff, mode_ff;
   logic [15:0] act_frames_ff, idle_frames_ff, row_period_ff, base_rows_ff;
   lp_seq_pkg::seq_state_e state_ff, nxt_state;
   logic [15:0] cnt_ff, row_clk_ff, row_cnt_ff, frame_cnt_ff;
   logic sync1_ff, sync2_ff, sync3_ff;
   logic row_tick, pin_rise, int_rise, low_mode, busy, trig;
   logic [6:0] mode_sel;
   logic [15:0] integ_rows;

   // address match used by both write and read decode
   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      hit = (a == o);
   endfunction

   // software writes; debug register resets to its mandated value
   // counts are written a byte at a time and each byte takes effect alone
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         out_pwr_ff <= `RST_ZERO;
         debug_ff <= `RST_DEBUG; // see [R17]
         power_opt_ff <= `RST_POWER_OPT;
         phase_ff <= `RST_PHASE_EN;
         mode_ff <= `RST_ZERO;
         act_frames_ff <= 16'h0001;
         idle_frames_ff <= 16'h0001;
         row_period_ff <= 16'h0001;
         base_rows_ff <= 16'h0001;
      end
      else if (reg_wr_i)
      begin
         if (hit(reg_addr_i, `A_SLEEP_OUT_PWR)) out_pwr_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `A_DEBUG_CTRL)) debug_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `A_POWER_OPT)) power_opt_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `A_PHASE_EN)) phase_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `A_SLEEP_MODE)) mode_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `A_ACT_HI)) act_frames_ff[15:8] <= reg_wdata_i;
         if (hit(reg_addr_i, `A_ACT_LO)) act_frames_ff[7:0] <= reg_wdata_i;
         if (hit(reg_addr_i, `A_IDLE_HI)) idle_frames_ff[15:8] <= reg_wdata_i;
         if (hit(reg_addr_i, `A_IDLE_LO)) idle_frames_ff[7:0] <= reg_wdata_i;
         if (hit(reg_addr_i, `A_ROWP_HI)) row_period_ff[15:8] <= reg_wdata_i; // see [R15]
         if (hit(reg_addr_i, `A_ROWP_LO)) row_period_ff[7:0] <= reg_wdata_i; // see [R15]
         if (hit(reg_addr_i, `A_BASE_HI)) base_rows_ff[15:8] <= reg_wdata_i;
         if (hit(reg_addr_i, `A_BASE_LO)) base_rows_ff[7:0] <= reg_wdata_i;
      end
   end

   // registered readback; unmapped addresses read zero
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         reg_rdata_o <= 8'h00;
      else
      begin
         unique case (1'b1)
            hit(reg_addr_i, `A_SLEEP_OUT_PWR): reg_rdata_o <= out_pwr_ff;
            hit(reg_addr_i, `A_DEBUG_CTRL): reg_rdata_o <= debug_ff;
            hit(reg_addr_i, `A_POWER_OPT): reg_rdata_o <= power_opt_ff;
            hit(reg_addr_i, `A_PHASE_EN): reg_rdata_o <= phase_ff;
            hit(reg_addr_i, `A_SLEEP_MODE): reg_rdata_o <= mode_ff;
            hit(reg_addr_i, `A_ACT_HI): reg_rdata_o <= act_frames_ff[15:8];
            hit(reg_addr_i, `A_ACT_LO): reg_rdata_o <= act_frames_ff[7:0];
            hit(reg_addr_i, `A_IDLE_HI): reg_rdata_o <= idle_frames_ff[15:8];
            hit(reg_addr_i, `A_IDLE_LO): reg_rdata_o <= idle_frames_ff[7:0];
            hit(reg_addr_i, `A_ROWP_HI): reg_rdata_o <= row_period_ff[15:8];
            hit(reg_addr_i, `A_ROWP_LO): reg_rdata_o <= row_period_ff[7:0];
            hit(reg_addr_i, `A_BASE_HI): reg_rdata_o <= base_rows_ff[15:8];
            hit(reg_addr_i, `A_BASE_LO): reg_rdata_o <= base_rows_ff[7:0];
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // trigger detection
   // -----------------------------------------------------------------

   // two flops against metastability, a third only for the edge
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= frame_sync_trigger_in_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // mode decode and trigger qualification
   assign low_mode = (power_opt_ff == `PWR_LOW) // see [R01]
      && (phase_ff[1:0] == `PHASE_LOW); // see [R02]
   assign mode_sel = mode_ff[6:0]; // see [R03]
   assign pin_rise = sync2_ff && !sync3_ff; // see [R19]
   // bit7 edge is taken from the write itself, so no poll is missed
   assign int_rise = reg_wr_i && hit(reg_addr_i, `A_SLEEP_MODE)
      && reg_wdata_i[`BIT_INT_TRIG] && !mode_ff[`BIT_INT_TRIG]; // see [R04]
   // only a sleeping sequencer may take a trigger
   assign busy = (state_ff != lp_seq_pkg::ST_SLEEP);
   // triggers during a burst are dropped, not queued
   assign trig = !busy && low_mode && (
      ((mode_sel == `MODE_INT_SNAP) && int_rise) // see [R07]
      || ((mode_sel == `MODE_EXT_SNAP) && pin_rise)); // see [R08] [R19]

   // -----------------------------------------------------------------
   // row and frame timing
   // -----------------------------------------------------------------

   // a zero row period behaves as one clock per row
   assign row_tick = (row_clk_ff >= row_period_ff - 16'h0001)
      || (row_period_ff == 16'h0000); // see [R15]

   // integration shortened by the low frame rate margin
   assign integ_rows = (base_rows_ff > `INTEG_MARGIN_ROWS)
      ? base_rows_ff - `INTEG_MARGIN_ROWS : 16'h0001; // see [R06]

   // next state of the sequencer
   // frame counts compare as count plus one, so a zero count acts as one
   // a zero base frame length wraps the row count, so a frame lasts 65536 rows; software must program it
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         lp_seq_pkg::ST_NORMAL:
            if (low_mode)
               nxt_state = (mode_sel == `MODE_LFR) ? lp_seq_pkg::ST_WAKE : lp_seq_pkg::ST_SLEEP;
         lp_seq_pkg::ST_SLEEP:
            if (trig)
               nxt_state = lp_seq_pkg::ST_WAKE;
         lp_seq_pkg::ST_WAKE:
            if (cnt_ff == 16'(WAKE_CYC - 1))
               nxt_state = lp_seq_pkg::ST_PIXRST; // see [R10]
         lp_seq_pkg::ST_PIXRST:
            if (row_tick && row_cnt_ff == `PIXRST_ROWS - 16'h0001)
               nxt_state = lp_seq_pkg::ST_STREAM; // see [R11]
         lp_seq_pkg::ST_STREAM:
            if (row_tick && row_cnt_ff == base_rows_ff - 16'h0001
               && frame_cnt_ff + 16'h0001 >= act_frames_ff)
               nxt_state = (mode_sel == `MODE_LFR) ? lp_seq_pkg::ST_IDLE // see [R05]
                  : lp_seq_pkg::ST_SLEEP; // see [R07] [R08]
         lp_seq_pkg::ST_IDLE:
            if (row_tick && row_cnt_ff == base_rows_ff - 16'h0001
               && frame_cnt_ff + 16'h0001 >= idle_frames_ff)
               nxt_state = lp_seq_pkg::ST_STREAM; // see [R05]
         default:
            nxt_state = lp_seq_pkg::ST_NORMAL;
      endcase
      if (!low_mode)
         nxt_state = lp_seq_pkg::ST_NORMAL;
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_ff <= lp_seq_pkg::ST_NORMAL;
      else
         state_ff <= nxt_state;
   end

   // clock counter: wake length, then the clock part of pixel reset
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt_ff <= 16'h0000;
      else if (nxt_state != state_ff)
         cnt_ff <= 16'h0000;
      else if (state_ff == lp_seq_pkg::ST_WAKE || state_ff == lp_seq_pkg::ST_PIXRST)
         cnt_ff <= cnt_ff + 16'h0001; // see [R10]
   end

   // row clock divider; held during wake and the extra reset clocks
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         row_clk_ff <= 16'h0000;
      else if (nxt_state != state_ff || state_ff == lp_seq_pkg::ST_WAKE
         || (state_ff == lp_seq_pkg::ST_PIXRST && cnt_ff < 16'(PIXRST_CYC)))
         row_clk_ff <= 16'h0000; // see [R11]
      else if (row_tick)
         row_clk_ff <= 16'h0000;
      else
         row_clk_ff <= row_clk_ff + 16'h0001;
   end

   // row within frame and frame within phase
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         row_cnt_ff <= 16'h0000;
         frame_cnt_ff <= 16'h0000;
      end
      else if (nxt_state != state_ff)
      begin
         row_cnt_ff <= 16'h0000;
         frame_cnt_ff <= 16'h0000;
      end
      else if (row_tick && !(state_ff == lp_seq_pkg::ST_PIXRST && cnt_ff < 16'(PIXRST_CYC)))
      begin
         if (row_cnt_ff == base_rows_ff - 16'h0001 && state_ff != lp_seq_pkg::ST_PIXRST)
         begin
            row_cnt_ff <= 16'h0000;
            frame_cnt_ff <= frame_cnt_ff + 16'h0001;
         end
         else
            row_cnt_ff <= row_cnt_ff + 16'h0001;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------

   // phase status levels taken from the next state so they lead nothing; the low power level comes from the mode decode
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         low_power_o <= 1'b0;
         asleep_o <= 1'b0;
         streaming_o <= 1'b1;
      end
      else
      begin
         low_power_o <= low_mode;
         asleep_o <= (nxt_state == lp_seq_pkg::ST_SLEEP || nxt_state == lp_seq_pkg::ST_IDLE);
         streaming_o <= (nxt_state == lp_seq_pkg::ST_STREAM || nxt_state == lp_seq_pkg::ST_NORMAL);
      end
   end

   // integration opens each streamed frame and closes after the capped row count
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         integrating_o <= 1'b0;
         integ_start_o <= 1'b0;
      end
      else
      begin
         integrating_o <= (nxt_state == lp_seq_pkg::ST_STREAM)
            && !(state_ff == lp_seq_pkg::ST_STREAM && row_tick && row_cnt_ff == integ_rows - 16'h0001)
            && (state_ff != lp_seq_pkg::ST_STREAM || row_cnt_ff < integ_rows
               || (row_tick && row_cnt_ff == base_rows_ff - 16'h0001)); // see [R06]
         integ_start_o <= (nxt_state == lp_seq_pkg::ST_STREAM)
            && (state_ff != lp_seq_pkg::ST_STREAM
               || (row_tick && row_cnt_ff == base_rows_ff - 16'h0001)); // see [R11]
      end
   end

   // frame start pulse trails the end of integration by a fixed row count
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         frame_start_o <= 1'b0;
      else
         frame_start_o <= (state_ff == lp_seq_pkg::ST_STREAM) && row_tick
            && (row_cnt_ff == integ_rows + `FS_DELAY_ROWS - 16'h0001); // see [R12]
   end

   // power down only ever applies while the sensor sleeps
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         output_pd_o <= 1'b0;
      else
         output_pd_o <= out_pwr_ff[`BIT_OUT_PD]
            && (nxt_state == lp_seq_pkg::ST_SLEEP || nxt_state == lp_seq_pkg::ST_IDLE); // see [R18]
   end

   // exposure ceiling for software; outside low frame rate the full frame is allowed
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         max_integ_rows_o <= 16'h0000;
      else
         max_integ_rows_o <= (low_mode && mode_sel == `MODE_LFR) ? integ_rows
            : base_rows_ff; // see [R06]
   end

endmodule
`default_nettype wire

// ### hdl/lp_seq_params.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef LP_SEQ_PARAMS_SVH
`define LP_SEQ_PARAMS_SVH
`define A_SLEEP_OUT_PWR 16'h3023
`define A_DEBUG_CTRL 16'h3C00
`define A_POWER_OPT 16'h3C01
`define A_PHASE_EN 16'h3C02
`define A_SLEEP_MODE 16'h3C03
`define A_ACT_HI 16'h3C04
`define A_ACT_LO 16'h3C05
`define A_IDLE_HI 16'h3C06
`define A_IDLE_LO 16'h3C07
`define A_ROWP_HI 16'h3C0C
`define A_ROWP_LO 16'h3C0D
`define A_BASE_HI 16'h3C0E
`define A_BASE_LO 16'h3C0F
`define RST_DEBUG 8'h89
`define RST_POWER_OPT 8'hAB
`define RST_PHASE_EN 8'h01
`define RST_ZERO 8'h00
`define PWR_LOW 8'h63
`define PWR_NORMAL 8'hAB
`define PHASE_LOW 2'h3
`define PHASE_NORMAL 2'h1
`define MODE_LFR 7'h00
`define MODE_INT_SNAP 7'h03
`define MODE_EXT_SNAP 7'h17
`define BIT_INT_TRIG 7
`define BIT_OUT_PD 1
`define WAKE_CYC 16384
`define EXP_DLY_CYC 16388
`define TRIG_LAT_CYC 3
`define PIXRST_ROWS 16'h000B
`define INTEG_MARGIN_ROWS 16'h0028
`define FS_DELAY_ROWS 16'h0008
`endif

// ### hdl/lp_seq_pkg.sv
// types shared by the low power frame sequencer
`default_nettype none
package lp_seq_pkg;
   typedef enum logic [2:0] {
      ST_NORMAL = 3'b000,
      ST_SLEEP = 3'b001,
      ST_WAKE = 3'b010,
      ST_PIXRST = 3'b011,
      ST_STREAM = 3'b100,
      ST_IDLE = 3'b101
   } seq_state_e;
endpackage
`default_nettype wire

// ### verif/lp_seq_checker.sv
// port level assertions for the low power frame sequencer
`include "lp_seq_params.svh"
`default_nettype none
// ----------------------------------------
// checker
// ----------------------------------------
module lp_seq_checker #(
   parameter int WAKE_CYC = `WAKE_CYC,
   parameter int EXP_DLY_CYC = `EXP_DLY_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register side
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // pin and sequencing outputs
   input wire logic frame_sync_trigger_in_i,
   input wire logic low_power_o,
   input wire logic asleep_o,
   input wire logic streaming_o,
   input wire logic integrating_o,
   input wire logic integ_start_o,
   input wire logic frame_start_o,
   input wire logic output_pd_o,
   input wire logic [15:0] max_integ_rows_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // power down only ever rides on sleep
   a_pd_only_asleep: assert property (output_pd_o |-> asleep_o)
      else $error("output power down outside sleep");
   a_integ_pulse_single: assert property (integ_start_o |=> !integ_start_o)
      else $error("integration start wider than one cycle");
   a_fs_pulse_single: assert property (frame_start_o |=> !frame_start_o)
      else $error("frame start wider than one cycle");
   a_fs_after_integ: assert property (frame_start_o |-> !integrating_o)
      else $error("frame start during integration");
   a_integ_follows: assert property (integ_start_o |-> ##[0:1] integrating_o)
      else $error("integration start without integration");
   a_start_streams: assert property (integ_start_o |-> ##[0:1] streaming_o)
      else $error("integration start outside streaming");
   a_sleep_no_stream: assert property (!(asleep_o && streaming_o))
      else $error("asleep and streaming together");
   // leaving low power must show within the register pipeline
   a_normal_exit: assert property (reg_wr_i && reg_addr_i == `A_POWER_OPT
      && reg_wdata_i == `PWR_NORMAL |-> ##3 (!low_power_o && streaming_o))
      else $error("normal write did not leave low power");
   a_phase_normal: assert property (reg_wr_i && reg_addr_i == `A_PHASE_EN
      && reg_wdata_i[1:0] == `PHASE_NORMAL |-> ##3 !low_power_o)
      else $error("normal phase write kept low power");
   a_debug_default: assert property (reg_addr_i == `A_DEBUG_CTRL |=> reg_rdata_o == `RST_DEBUG)
      else $error("debug register lost its value");
endmodule

bind low_power_frame_sequencer lp_seq_checker #(.WAKE_CYC(WAKE_CYC), .EXP_DLY_CYC(EXP_DLY_CYC)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .frame_sync_trigger_in_i(frame_sync_trigger_in_i),
   .low_power_o(low_power_o), .asleep_o(asleep_o), .streaming_o(streaming_o), .integrating_o(integrating_o),
   .integ_start_o(integ_start_o), .frame_start_o(frame_start_o), .output_pd_o(output_pd_o),
   .max_integ_rows_o(max_integ_rows_o));
`default_nettype wire

// ### verif/lp_seq_host.sv
// trigger pin driver standing in for the host controller
`default_nettype none
module lp_seq_host (
   // clock
   input wire logic clk_i,
   // trigger pin towards the sequencer
   output logic frame_sync_trigger_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // pin rests low between pulses
   initial frame_sync_trigger_in_o = 1'b0;
   // shorter requests are stretched, a narrow pulse could slip past the sync stage
   // gaps between bursts stay far below the long-sleep limit, so no frame is discarded
   task automatic pulse(input int width);
      frame_sync_trigger_in_o = 1'b1;
      repeat ((width < 5) ? 5 : width) @(negedge clk_i);
      frame_sync_trigger_in_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the low power frame sequencer
`include "lp_seq_params.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // stimulus and checks
   // ----------------------------------------
   localparam int ROW = 4;
   // shortened wake and exposure delay so a burst fits in a few hundred cycles
   localparam int WAKE = 16;
   localparam int EXP = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic trig;
   logic low_power, asleep, streaming, integrating, integ_start, frame_start, out_pd;
   logic [15:0] max_rows;
   logic [23:0] cfg [8] = '{24'h3C0C00, 24'h3C0D04, 24'h3C0E00, 24'h3C0F30,
      24'h3C0400, 24'h3C0502, 24'h3C0600, 24'h3C0701};
   int n_mismatch = 0;
   int checks_done = 0;
   int n, lat, fsd, il, t;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   low_power_frame_sequencer #(.WAKE_CYC(WAKE), .EXP_DLY_CYC(EXP)) DUT (.clk_i(clk), .rst_i(rst),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .frame_sync_trigger_in_i(trig), .low_power_o(low_power), .asleep_o(asleep), .streaming_o(streaming),
      .integrating_o(integrating), .integ_start_o(integ_start), .frame_start_o(frame_start),
      .output_pd_o(out_pd), .max_integ_rows_o(max_rows));
   lp_seq_host host (.clk_i(clk), .frame_sync_trigger_in_o(trig));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // cycle counts may wander a little through the output registers
   task automatic near(input int got, input int exp, input int tol);
      chk(16'((got >= exp - tol && got <= exp + tol) ? exp : got), 16'(exp));
   endtask
   // one write, strobe low again before the next may start
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
      addr = a;
      @(negedge clk);
      chk({8'h00, rdata}, {8'h00, exp});
   endtask
   // counts integration starts of one burst until the block sleeps again;
   // the present cycle is looked at first, so a frame opening at the call is kept
   task automatic burst(input int limit);
      logic prev;
      int f;
      n = 0;
      lat = -1;
      fsd = -1;
      il = -1;
      f = 0;
      prev = 1'b0;
      for (t = 0; t < limit; t++)
      begin
         if (integ_start === 1'b1)
         begin
            if (n == 0)
               lat = t;
            n++;
         end
         if (prev === 1'b1 && integrating === 1'b0)
         begin
            f = t;
            if (il < 0)
               il = t - lat;
         end
         if (frame_start === 1'b1 && fsd < 0)
            fsd = t - f;
         prev = integrating;
         if (n > 0 && asleep === 1'b1)
            break;
         @(negedge clk);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence: reset values, setup, then each burst mode in turn
   initial
   begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      rreg(`A_DEBUG_CTRL, `RST_DEBUG);
      rreg(`A_POWER_OPT, `RST_POWER_OPT);
      rreg(`A_PHASE_EN, `RST_PHASE_EN);
      rreg(16'h3C08, 8'h00);
      chk(streaming, 1'b1);
      foreach (cfg[i])
      begin
         wreg(cfg[i][23:8], cfg[i][7:0]);
         rreg(cfg[i][23:8], cfg[i][7:0]);
      end
      wreg(`A_SLEEP_MODE, {1'b0, `MODE_EXT_SNAP});
      wreg(`A_PHASE_EN, 8'h03);
      wreg(`A_POWER_OPT, `PWR_LOW);
      chk(low_power, 1'b1);
      repeat (4) @(negedge clk);
      chk(asleep, 1'b1);
      chk(max_rows, 16'h0030);
      wreg(`A_SLEEP_OUT_PWR, 8'h02);
      chk(out_pd, 1'b1);
      wreg(`A_SLEEP_OUT_PWR, 8'h00);
      chk(out_pd, 1'b0);
      // second pulse lands mid-burst and must be dropped
      fork
         host.pulse(5);
         burst(3000);
         begin
            repeat (150) @(negedge clk);
            host.pulse(6);
         end
      join
      chk(16'(n), 16'h0002);
      near(lat, EXP + 11 * ROW, 3);
      chk(16'(il), 16'(8 * ROW));
      near(fsd, 8 * ROW, 2);
      chk(asleep, 1'b1);
      // a fresh pulse is taken again once the block sleeps
      fork
         host.pulse(5);
         burst(3000);
      join
      chk(16'(n), 16'h0002);
      near(lat, EXP + 11 * ROW, 3);
      wreg(`A_SLEEP_MODE, {1'b0, `MODE_INT_SNAP});
      wreg(`A_SLEEP_MODE, 8'h83);
      burst(3000);
      chk(16'(n), 16'h0002);
      wreg(`A_SLEEP_MODE, 8'h83);
      burst(400);
      chk(16'(n), 16'h0000);
      // phase field alone also leaves and re-enters low power
      wreg(`A_PHASE_EN, 8'h01);
      chk(low_power, 1'b0);
      chk(streaming, 1'b1);
      wreg(`A_PHASE_EN, 8'h03);
      chk(low_power, 1'b1);
      wreg(`A_POWER_OPT, `PWR_NORMAL);
      chk(streaming, 1'b1);
      chk(low_power, 1'b0);
      wreg(`A_SLEEP_MODE, {1'b0, `MODE_LFR});
      wreg(`A_POWER_OPT, `PWR_LOW);
      chk(max_rows, 16'h0008);
      burst(3000);
      chk(16'(n), 16'h0002);
      chk(16'(il), 16'(8 * ROW));
      t = 0;
      while (asleep === 1'b1 && t < 2000)
      begin
         @(negedge clk);
         t++;
      end
      near(t, 48 * ROW, 4);
      burst(3000);
      chk(16'(n), 16'h0002);
      wrap_up();
   end
   // watchdog, far beyond the few thousand cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
